// >>> core/amp_self_diag_status_readout.sv
// two-wire slave holding the instruction bytes and serving four status bytes
// assumes bus pins and detector levels are synchronous to ref_clk_in
//
// Function
// [RQ1] byte 3 bits 0-3: channel 3 short gnd, short supply, open/offset, short load
// [RQ2] bit 4 of a channel byte: 1 permanent diagnosis, 0 turn-on diagnosis
// [RQ3] bit 5: tweeter current low flag, only while current detection enabled
// [RQ4] byte 3 bit 6 mirrors the diagnostic-cycle enable setting
// [RQ5] byte 3 bit 7 mirrors the standby setting, 1 when playing
// [RQ6] byte 4 bits 0-3: channel 4 faults; bits 6-7 carry nothing
// [RQ7] short protection acts per channel independently
// [RQ8] host sets diag enable in the same write that turns amplifier on
// [RQ9] host reads turn-on results only after the acquisition period
// [RQ10] with diag enabled, reads may repeat the turn-on diagnosis
// [RQ11] mode bit: 1 one-shot turn-on diagnosis, 0 repeat mode
// [RQ12] one-shot: first read invalid, host reads once more than needed
// [RQ13] permanent diagnosis runs after turn-on regardless of diag enable
// [RQ14] a read alone returns results, no write needed first
// [RQ15] short faults held so the first read after clearing still shows them
// [RQ16] host confirms a short only after three reporting reads
// [RQ17] offset flag is live, never latched
// [RQ18] host spaces offset reads by a signal period, needs two faulty results
// [RQ19] a write can switch the clip pin to carry the offset detector
// [RQ20] host reads tweeter check at least one signal cycle after unmute
// [RQ21] first read byte bit 7 is the thermal warning
// [RQ22] host reads every result at least twice
// [RQ23] slave address byte D8 hex, lsb 0 write, 1 read
// [RQ24] second instruction byte bit 2 enables current detection
// [RQ25] bits 6 and 7 of the fourth byte read as zero
`timescale 1ns/10ps
`default_nettype none
module amp_self_diag_status_readout #(
    parameter int ACQ_CYCLES = amp_diag_pkg::ACQ_CYCLES
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n_out,
    input wire logic [3:0] short_gnd_in,
    input wire logic [3:0] short_vcc_in,
    input wire logic [3:0] short_load_in,
    input wire logic [3:0] open_load_in,
    input wire logic [3:0] offset_det_in,
    input wire logic [3:0] cur_low_in,
    input wire logic thermal_warn_in,
    input wire logic clip_det_in,
    output logic [7:0] first_instruction_byte_out,
    output logic [7:0] second_instruction_byte_out,
    output logic [3:0] protect_out,
    output logic clip_pin_out,
    output logic turn_on_active_out
);
    localparam int CH = amp_diag_pkg::CHANNELS;

    generate
        if (ACQ_CYCLES < 1) begin : g_bad
            $error("amp_self_diag_status_readout: ACQ_CYCLES must be at least 1");
        end
    endgenerate

    function automatic logic [7:0] chan_byte(
        input logic sgnd,
        input logic svcc,
        input logic open_offs,
        input logic sload,
        input logic perm,
        input logic cur,
        input logic b6,
        input logic b7
    );
        logic [7:0] b;
        b = '0;
        b[amp_diag_pkg::ST_SGND] = sgnd;
        b[amp_diag_pkg::ST_SVCC] = svcc;
        b[amp_diag_pkg::ST_OPEN] = open_offs;
        b[amp_diag_pkg::ST_SLOAD] = sload;
        b[amp_diag_pkg::ST_PERM] = perm;
        b[amp_diag_pkg::ST_CUR] = cur;
        b[amp_diag_pkg::ST_B6] = b6;
        b[amp_diag_pkg::ST_B7] = b7;
        return b;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // bus condition detect
    logic scl_q;
    logic sda_q;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else if (clk_en_in) begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    assign scl_rise = ~scl_q & scl_in;
    assign scl_fall = scl_q & ~scl_in;
    assign start_det = scl_q & scl_in & sda_q & ~sda_in;
    assign stop_det = scl_q & scl_in & ~sda_q & sda_in;

    ////////////////////////////////////////////////////////////////////////
    // status assembly
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [3*CH-1:0] held;
    logic diag_terminated;
    logic perm;
    logic offs_en;
    logic cur_en;
    logic [7:0] status [CH];
    logic [CH-1:0] open_offs;
    logic [CH-1:0] cur_flag;

    assign offs_en = ctrl1[amp_diag_pkg::IB1_OFFS_EN];
    assign cur_en = ctrl2[amp_diag_pkg::IB2_CUR_EN]; // see [RQ24]
    // permanent diagnosis covers all time in play outside the turn-on window
    assign perm = ctrl2[amp_diag_pkg::IB2_PLAY] & ~turn_on_active_out; // see [RQ13]

    always_comb begin
        for (int c = 0; c < CH; c++) begin
            // offset taken live from the detector, open load during turn-on
            open_offs[c] = perm ? (offset_det_in[c] & offs_en) : open_load_in[c]; // see [RQ17]
            cur_flag[c] = cur_low_in[c] & cur_en; // see [RQ3]
        end
    end

    always_comb begin
        status[0] = chan_byte(held[0], held[CH], open_offs[0], held[2*CH], perm,
            cur_flag[0], diag_terminated, thermal_warn_in); // see [RQ21] [RQ2]
        status[1] = chan_byte(held[1], held[CH+1], open_offs[1], held[2*CH+1], perm,
            cur_flag[1], cur_en, offs_en);
        status[2] = chan_byte(held[2], held[CH+2], open_offs[2], held[2*CH+2], perm,
            cur_flag[2], ctrl1[amp_diag_pkg::IB1_DIAG_EN],
            ctrl2[amp_diag_pkg::IB2_PLAY]); // see [RQ1] [RQ4] [RQ5]
        status[3] = chan_byte(held[3], held[CH+3], open_offs[3], held[2*CH+3], perm,
            cur_flag[3], 1'b0, 1'b0); // see [RQ6] [RQ25]
    end

    ////////////////////////////////////////////////////////////////////////
    // bus state machine
    amp_diag_pkg::bus_state_t state;
    logic [2:0] bit_cnt;
    logic [7:0] rx;
    logic [7:0] tx;
    logic [1:0] rd_idx;
    logic is_read;
    logic mst_ack;
    logic byte_end;
    logic addr_match;
    logic read_start;
    logic read_done;
    logic sub_load;
    logic wr_now;

    assign byte_end = scl_fall & (bit_cnt == amp_diag_pkg::BIT_LAST);
    assign addr_match = (rx[7:1] == amp_diag_pkg::ADDR_BYTE[7:1]); // see [RQ23]
    // a read address alone serves the status bytes
    assign read_start = clk_en_in & byte_end & (state == amp_diag_pkg::BUS_ADDR)
        & addr_match & rx[0]; // see [RQ14]
    assign read_done = clk_en_in & scl_fall & (state == amp_diag_pkg::BUS_RACK)
        & ~mst_ack;
    assign sub_load = clk_en_in & byte_end & (state == amp_diag_pkg::BUS_SUB);
    assign wr_now = clk_en_in & byte_end & (state == amp_diag_pkg::BUS_DATA);

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= amp_diag_pkg::BUS_IDLE;
            bit_cnt <= amp_diag_pkg::BIT_FIRST;
            rx <= '0;
            tx <= '0;
            rd_idx <= amp_diag_pkg::RD_FIRST;
            is_read <= 1'b0;
            mst_ack <= 1'b0;
            sda_out <= 1'b1;
            sda_oe_n_out <= 1'b1;
        end else if (clk_en_in) begin
            if (start_det) begin
                state <= amp_diag_pkg::BUS_START;
                bit_cnt <= amp_diag_pkg::BIT_FIRST;
                sda_out <= 1'b1;
                sda_oe_n_out <= 1'b1;
            end else if (stop_det) begin
                state <= amp_diag_pkg::BUS_IDLE;
                sda_out <= 1'b1;
                sda_oe_n_out <= 1'b1;
            end else if (scl_rise) begin
                case (state)
                    amp_diag_pkg::BUS_ADDR,
                    amp_diag_pkg::BUS_SUB,
                    amp_diag_pkg::BUS_DATA: begin
                        rx <= {rx[6:0], sda_in};
                    end
                    amp_diag_pkg::BUS_RACK: begin
                        mst_ack <= ~sda_in;
                    end
                    default: begin
                    end
                endcase
            end else if (scl_fall) begin
                case (state)
                    amp_diag_pkg::BUS_ADDR,
                    amp_diag_pkg::BUS_SUB,
                    amp_diag_pkg::BUS_DATA: begin
                        bit_cnt <= bit_cnt + 1'b1;
                        if (bit_cnt == amp_diag_pkg::BIT_LAST) begin
                            // foreign addresses are left alone until the next start
                            if (state == amp_diag_pkg::BUS_ADDR && !addr_match) begin
                                state <= amp_diag_pkg::BUS_IDLE;
                            end else begin
                                sda_out <= 1'b0;
                                sda_oe_n_out <= 1'b0;
                                case (state)
                                    amp_diag_pkg::BUS_ADDR: state <= amp_diag_pkg::BUS_AACK;
                                    amp_diag_pkg::BUS_SUB: state <= amp_diag_pkg::BUS_SACK;
                                    default: state <= amp_diag_pkg::BUS_DACK;
                                endcase
                            end
                            if (state == amp_diag_pkg::BUS_ADDR) begin
                                is_read <= rx[0];
                            end
                        end
                    end
                    amp_diag_pkg::BUS_START: state <= amp_diag_pkg::BUS_ADDR;
                    amp_diag_pkg::BUS_AACK: begin
                        bit_cnt <= amp_diag_pkg::BIT_FIRST;
                        if (is_read) begin
                            // every read begins with the first status byte
                            state <= amp_diag_pkg::BUS_RDATA;
                            rd_idx <= amp_diag_pkg::RD_FIRST;
                            tx <= {status[0][6:0], 1'b1};
                            sda_out <= status[0][7];
                            sda_oe_n_out <= status[0][7];
                        end else begin
                            state <= amp_diag_pkg::BUS_SUB;
                            sda_out <= 1'b1;
                            sda_oe_n_out <= 1'b1;
                        end
                    end
                    amp_diag_pkg::BUS_SACK,
                    amp_diag_pkg::BUS_DACK: begin
                        state <= amp_diag_pkg::BUS_DATA;
                        bit_cnt <= amp_diag_pkg::BIT_FIRST;
                        sda_out <= 1'b1;
                        sda_oe_n_out <= 1'b1;
                    end
                    amp_diag_pkg::BUS_RDATA: begin
                        bit_cnt <= bit_cnt + 1'b1;
                        if (bit_cnt == amp_diag_pkg::BIT_LAST) begin
                            state <= amp_diag_pkg::BUS_RACK;
                            sda_out <= 1'b1;
                            sda_oe_n_out <= 1'b1;
                        end else begin
                            tx <= {tx[6:0], 1'b1};
                            sda_out <= tx[7];
                            sda_oe_n_out <= tx[7];
                        end
                    end
                    amp_diag_pkg::BUS_RACK: begin
                        bit_cnt <= amp_diag_pkg::BIT_FIRST;
                        if (mst_ack) begin
                            // bytes wrap back to the first after the fourth
                            state <= amp_diag_pkg::BUS_RDATA;
                            rd_idx <= rd_idx + 1'b1;
                            tx <= {status[rd_idx + 1'b1][6:0], 1'b1};
                            sda_out <= status[rd_idx + 1'b1][7];
                            sda_oe_n_out <= status[rd_idx + 1'b1][7];
                        end else begin
                            state <= amp_diag_pkg::BUS_IDLE;
                        end
                    end
                    default: begin
                        state <= amp_diag_pkg::BUS_IDLE;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // instruction bytes; sub address bit 7 turns on auto increment
    logic [6:0] sub_ptr;
    logic autoinc;

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sub_ptr <= '0;
            autoinc <= 1'b0;
            ctrl1 <= amp_diag_pkg::CTRL_RESET;
            ctrl2 <= amp_diag_pkg::CTRL_RESET;
        end else if (sub_load) begin
            sub_ptr <= rx[6:0];
            autoinc <= rx[amp_diag_pkg::SUB_AUTOINC];
        end else if (wr_now) begin
            // unmapped sub addresses are acknowledged but not stored
            if (sub_ptr == amp_diag_pkg::SUB_CTRL1) begin
                ctrl1 <= rx;
            end
            if (sub_ptr == amp_diag_pkg::SUB_CTRL2) begin
                ctrl2 <= rx;
            end
            if (autoinc) begin
                sub_ptr <= sub_ptr + 1'b1;
            end
        end
    end

    assign first_instruction_byte_out = ctrl1;
    assign second_instruction_byte_out = ctrl2;

    ////////////////////////////////////////////////////////////////////////
    // fault holding, per-channel protection and the clip pin
    short_fault_hold #(
        .WIDTH(3 * CH)
    ) u_hold (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .clk_en_in(clk_en_in),
        .fault_in({short_load_in, short_vcc_in, short_gnd_in}),
        .clr_in(read_done),
        .held_out(held)
    );

    turn_on_diag #(
        .ACQ_CYCLES(ACQ_CYCLES)
    ) u_turn_on (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .clk_en_in(clk_en_in),
        .play_in(ctrl2[amp_diag_pkg::IB2_PLAY]),
        .diag_en_in(ctrl1[amp_diag_pkg::IB1_DIAG_EN]),
        .one_shot_in(ctrl1[amp_diag_pkg::IB1_ONE_SHOT]),
        .read_start_in(read_start),
        .active_out(turn_on_active_out),
        .terminated_out(diag_terminated)
    );

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            protect_out <= '0;
            clip_pin_out <= 1'b0;
        end else if (clk_en_in) begin
            // each channel guards only itself; the others keep playing
            protect_out <= short_gnd_in | short_vcc_in | short_load_in; // see [RQ7]
            clip_pin_out <= ctrl2[amp_diag_pkg::IB2_PIN_OFFS]
                ? (|offset_det_in) : clip_det_in; // see [RQ19]
        end
    end
endmodule // amp_self_diag_status_readout
`default_nettype wire

// >>> core/amp_diag_pkg.sv
// constants, field positions and states shared by the diagnosis readout
// assumes a 50 MHz reference clock
package amp_diag_pkg;
    localparam logic [7:0] ADDR_BYTE = 8'hD8;
    localparam logic [6:0] SUB_CTRL1 = 7'h01;
    localparam logic [6:0] SUB_CTRL2 = 7'h02;
    localparam int SUB_AUTOINC = 7;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // first instruction byte
    localparam int IB1_ONE_SHOT = 7;
    localparam int IB1_DIAG_EN = 6;
    localparam int IB1_OFFS_EN = 5;
    // second instruction byte
    localparam int IB2_CUR_SEL = 7;
    localparam int IB2_PIN_OFFS = 5;
    localparam int IB2_PLAY = 4;
    localparam int IB2_CUR_EN = 2;
    // status byte fields
    localparam int ST_SGND = 0;
    localparam int ST_SVCC = 1;
    localparam int ST_OPEN = 2;
    localparam int ST_SLOAD = 3;
    localparam int ST_PERM = 4;
    localparam int ST_CUR = 5;
    localparam int ST_B6 = 6;
    localparam int ST_B7 = 7;
    localparam int CHANNELS = 4;
    localparam logic [1:0] RD_FIRST = 2'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    // turn-on acquisition window
    localparam int CLK_PERIOD_NS = 20;
    localparam int ACQ_TIME_MS = 100;
    localparam int ACQ_CYCLES = ACQ_TIME_MS * 1000000 / CLK_PERIOD_NS;
    typedef enum logic [3:0] {
        BUS_IDLE, BUS_START, BUS_ADDR, BUS_AACK, BUS_SUB, BUS_SACK,
        BUS_DATA, BUS_DACK, BUS_RDATA, BUS_RACK
    } bus_state_t;
endpackage

// >>> core/short_fault_hold.sv
// holds short-fault flags until a read finds the fault gone
// assumes clr_in is a one-cycle pulse at the end of a status read
`timescale 1ns/10ps
`default_nettype none
module short_fault_hold #(
    parameter int WIDTH = 12
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire logic [WIDTH-1:0] fault_in,
    input wire logic clr_in,
    output logic [WIDTH-1:0] held_out
);
    generate
        if (WIDTH < 1) begin : g_bad
            $error("short_fault_hold: WIDTH must be at least 1");
        end
    endgenerate

    // a fault present in the clearing cycle sets again, so set wins
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            held_out <= '0;
        end else if (clk_en_in) begin
            held_out <= fault_in | (clr_in ? '0 : held_out); // see [RQ15]
        end
    end
endmodule // short_fault_hold
`default_nettype wire

// >>> core/turn_on_diag.sv
// turn-on diagnosis sequencer: acquisition window after play, repeat on read
// assumes read_start_in is a one-cycle pulse per read address phase
`timescale 1ns/10ps
`default_nettype none
module turn_on_diag #(
    parameter int ACQ_CYCLES = amp_diag_pkg::ACQ_CYCLES
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire logic play_in,
    input wire logic diag_en_in,
    input wire logic one_shot_in,
    input wire logic read_start_in,
    output logic active_out,
    output logic terminated_out
);
    localparam int CW = $clog2(ACQ_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(ACQ_CYCLES - 1);
    logic play_q;
    logic [CW-1:0] cnt;
    logic start;

    generate
        if (ACQ_CYCLES < 1) begin : g_bad
            $error("turn_on_diag: ACQ_CYCLES must be at least 1");
        end
    endgenerate

    // diagnosis starts with the write that turns the amplifier on;
    // in repeat mode each read restarts it once the window is over
    assign start = diag_en_in & play_in
        & ((~play_q) | (~one_shot_in & read_start_in & ~active_out)); // see [RQ8] [RQ10] [RQ11]

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            play_q <= 1'b0;
        end else if (clk_en_in) begin
            play_q <= play_in;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            active_out <= 1'b0;
            terminated_out <= 1'b0;
            cnt <= '0;
        end else if (clk_en_in) begin
            if (!play_in) begin
                active_out <= 1'b0;
                terminated_out <= 1'b0;
                cnt <= '0;
            end else if (start) begin
                active_out <= 1'b1;
                terminated_out <= 1'b0;
                cnt <= '0;
            end else if (active_out) begin
                if (cnt == LAST) begin
                    active_out <= 1'b0;
                    terminated_out <= 1'b1;
                end else begin
                    cnt <= cnt + 1'b1;
                end
            end
        end
    end
endmodule // turn_on_diag
`default_nettype wire

// >>> bench/amp_diag_props.sv
// concurrent checks on the ports of the diagnosis readout
// assumes it is bound into amp_self_diag_status_readout with clk_en_in high
`timescale 1ns/10ps
`default_nettype none
module amp_diag_props #(
    parameter int ACQ_CYCLES = 20
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n_out,
    input wire logic [3:0] short_gnd_in,
    input wire logic [3:0] short_vcc_in,
    input wire logic [3:0] short_load_in,
    input wire logic [3:0] offset_det_in,
    input wire logic clip_det_in,
    input wire logic [7:0] first_instruction_byte_out,
    input wire logic [7:0] second_instruction_byte_out,
    input wire logic [3:0] protect_out,
    input wire logic clip_pin_out,
    input wire logic turn_on_active_out
);
    int unsigned win_len;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            win_len <= 0;
        end else begin
            win_len <= turn_on_active_out ? win_len + 1 : 0;
        end
    end
    sequence play_on_s;
        $rose(second_instruction_byte_out[4]) && first_instruction_byte_out[6];
    endsequence
    // start and stop move sda while scl is high, so only a quiet bit counts
    sequence bit_hold_s;
        (scl_in && $stable(sda_in)) [*3];
    endsequence
    protect_live_a: assert property (
        $past(rst_n_in) && $past(clk_en_in) |-> protect_out ==
        ($past(short_gnd_in) | $past(short_vcc_in) | $past(short_load_in))) else $error("protect");
    clip_route_a: assert property (
        $past(rst_n_in) && $past(clk_en_in) |-> clip_pin_out == ($past(second_instruction_byte_out[5])
        ? |$past(offset_det_in) : $past(clip_det_in))) else $error("clip pin");
    drive_pair_a: assert property (
        sda_oe_n_out == sda_out) else $error("sda drive pair");
    drive_start_a: assert property (
        $fell(sda_oe_n_out) |-> !scl_in) else $error("sda driven in scl high");
    bit_hold_a: assert property (
        bit_hold_s |-> $stable(sda_oe_n_out)) else $error("sda moved in scl high");
    win_start_a: assert property (
        play_on_s |-> ##[0:2] turn_on_active_out) else $error("turn-on not started");
    win_len_a: assert property (
        $fell(turn_on_active_out) && $past(second_instruction_byte_out[4]) |->
        win_len >= ACQ_CYCLES - 1 && win_len <= ACQ_CYCLES + 1) else $error("window length");
    standby_a: assert property (
        !second_instruction_byte_out[4] |=> !turn_on_active_out) else $error("window in standby");
endmodule // amp_diag_props
bind amp_self_diag_status_readout amp_diag_props #(.ACQ_CYCLES(ACQ_CYCLES)) props (.*);
`default_nettype wire

// >>> bench/amp_host_model.sv
// host controller on the two-wire bus: start, stop, byte frames
// assumes sda_wire_in is the resolved wire with a pull-up
`timescale 1ns/10ps
`default_nettype none
module amp_host_model (
    input wire logic clk_in,
    input wire logic sda_wire_in,
    output logic scl_out,
    output logic sda_drv_out
);
    initial begin
        scl_out = 1'b1;
        sda_drv_out = 1'b1;
    end
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    // nine bits: data set while scl low, wire taken late in the high phase
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            sda_drv_out = tx[i];
            wait_n(3);
            scl_out = 1'b1;
            wait_n(3);
            rx[i] = sda_wire_in;
            scl_out = 1'b0;
            wait_n(1);
        end
    endtask
    task automatic start_c;
        wait_n(3);
        sda_drv_out = 1'b0;
        wait_n(3);
        scl_out = 1'b0;
        wait_n(1);
    endtask
    task automatic stop_c;
        sda_drv_out = 1'b0;
        wait_n(3);
        scl_out = 1'b1;
        wait_n(3);
        sda_drv_out = 1'b1;
        wait_n(3);
    endtask
    // one transaction, so play and diag enable land together
    task automatic write2(input logic [7:0] sub, c1, c2, output logic nak);
        logic [8:0] rx;
        logic [35:0] frame;
        frame = {amp_diag_pkg::ADDR_BYTE, 1'b1, sub, 1'b1, c1, 1'b1, c2, 1'b1};
        nak = 1'b0;
        start_c();
        for (int k = 3; k >= 0; k--) begin
            xfer(frame[k*9 +: 9], rx);
            nak |= rx[0];
        end
        stop_c();
    endtask
    task automatic read4(input logic [7:0] addr, output logic nak, output logic [31:0] d);
        logic [8:0] rx;
        start_c();
        xfer({addr, 1'b1}, rx);
        nak = rx[0];
        d = '0;
        for (int k = 3; k >= 0 && !nak; k--) begin
            xfer({8'hFF, k == 0}, rx);
            d[k*8 +: 8] = rx[8:1];
        end
        stop_c();
    endtask
endmodule // amp_host_model
`default_nettype wire

// >>> bench/amp_self_diag_status_readout_bench.sv
// self-checking bench: random detector levels and control bytes, status reads
// assumes the host model, the bound checker and a short acquisition window
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e, m) begin n_tests++; if ((a) !== (e)) begin fails++; \
    $display("unexpected %0t %s", $time, m); end end
module amp_self_diag_status_readout_bench;
    localparam int ACQ = 20;
    logic ref_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic scl, host_sda, sda_wire, sda_o, sda_oe_n, therm, clip, clip_o, act, seen, nak;
    logic [3:0] sg, sv, sl, op, of, cl, pg, pv, pl, prot;
    logic [7:0] c1, c2, ib1, ib2;
    logic [31:0] rd;
    int fails = 0;
    int n_tests = 0;
    int seed = 32'ha334_8730;
    assign sda_wire = host_sda & (sda_oe_n | sda_o);
    amp_self_diag_status_readout #(.ACQ_CYCLES(ACQ)) DUT (
        .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .clk_en_in(1'b1),
        .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_o), .sda_oe_n_out(sda_oe_n),
        .short_gnd_in(sg), .short_vcc_in(sv), .short_load_in(sl), .open_load_in(op),
        .offset_det_in(of), .cur_low_in(cl), .thermal_warn_in(therm), .clip_det_in(clip),
        .first_instruction_byte_out(ib1), .second_instruction_byte_out(ib2),
        .protect_out(prot), .clip_pin_out(clip_o), .turn_on_active_out(act));
    amp_host_model host (.clk_in(ref_clk_in), .sda_wire_in(sda_wire), .scl_out(scl),
        .sda_drv_out(host_sda));
    initial begin
        forever #10 ref_clk_in = ~ref_clk_in;
    end
    always @(posedge ref_clk_in) seen <= seen | (act === 1'b1);
    ////////////////////////////////////////////////////////////////////////////////
    // shorts stay held from the read before, since they only clear at a read end
    function automatic logic [7:0] exp_b(input int k);
        logic opn;
        opn = c2[4] ? of[k] & c1[5] : op[k];
        return {k == 2 ? {c2[4], c1[6]} : 2'b00, cl[k] & c2[2], c2[4], sl[k] | pl[k], opn,
            sv[k] | pv[k], sg[k] | pg[k]};
    endfunction
    task automatic rd_chk;
        {sg, sv, sl, op, of, cl, therm, clip} = 26'($random(seed));
        seen = 1'b0;
        host.read4(amp_diag_pkg::ADDR_BYTE | 8'h01, nak, rd);
        `CHK(nak, 1'b0, "read ack")
        `CHK(rd[15:8], exp_b(2), "byte 3")
        `CHK(rd[7:0], exp_b(3), "byte 4")
        `CHK(rd[31], therm, "thermal")
        `CHK(seen, c1[6] & ~c1[7] & c2[4], "repeat diag")
        {pg, pv, pl} = {sg, sv, sl};
    endtask
    task automatic finish_test;
        if (fails == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        int k;
        {sg, sv, sl, op, of, cl, therm, clip, pg, pv, pl, seen} = '0;
        c1 = amp_diag_pkg::CTRL_RESET;
        c2 = amp_diag_pkg::CTRL_RESET;
        repeat (16) @(negedge ref_clk_in);
        rst_n_in = 1'b1;
        repeat (2) @(negedge ref_clk_in);
        `CHK({ib1, ib2}, {c1, c2}, "ctrl reset")
        rd_chk();
        host.read4(8'hDB, nak, rd);
        `CHK(nak, 1'b1, "foreign address")
        c1 = 8'($random(seed)) | 8'hC0;
        c2 = (8'($random(seed)) & 8'hBF) | 8'h10;
        seen = 1'b0;
        host.write2({1'b1, amp_diag_pkg::SUB_CTRL1}, c1, c2, nak);
        `CHK({nak, ib1, ib2, seen}, {1'b0, c1, c2, 1'b1}, "turn-on start")
        repeat (ACQ + 4) @(negedge ref_clk_in);
        `CHK(act, 1'b0, "turn-on end")
        repeat (2) rd_chk();
        for (k = 0; k < 6; k++) begin
            c1 = 8'($random(seed)) | 8'h40;
            c1[7] = k[0];
            c2 = 8'($random(seed)) & 8'hBF;
            c2[4] = (k != 5);
            host.write2({1'b1, amp_diag_pkg::SUB_CTRL1}, c1, c2, nak);
            host.write2(8'h05, ~c1, ~c2, nak);
            `CHK({nak, ib1, ib2}, {1'b0, c1, c2}, "ctrl write")
            repeat (2) rd_chk();
        end
        finish_test();
    end
    initial begin
        repeat (30000) @(negedge ref_clk_in);
        fails++;
        finish_test();
    end
endmodule // amp_self_diag_status_readout_bench
`default_nettype wire
